// *** verilog/gamma_common_voltage_channel_pkg.sv ***
// Shared constants for the gamma / common-voltage register block and its
// two-wire host controller.
// Assumes a single 10 MHz system clock on both ends.
`default_nettype none
package gamma_common_voltage_channel_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int NV_PROG_US = 250;
  localparam int NV_PROG_CYCLES = NV_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int RELOAD_US = 750;
  localparam int RELOAD_CYCLES = RELOAD_US * 1000 / CLK_PERIOD_NS;
  localparam int SCL_QTR_CYCLES = 25;

  localparam logic [6:0] BUS_ADDR = 7'h74;

  localparam logic [5:0] PTR_CH8 = 6'h07;
  localparam logic [5:0] PTR_COMMON_VOLTAGE_CHANNEL = 6'h12;
  localparam logic [5:0] PTR_ACK_TOP = 6'h17;
  localparam logic [5:0] PTR_HI = 6'h1e;
  localparam logic [5:0] PTR_LO = 6'h1f;
  localparam logic [5:0] PTR_REV = 6'h3c;
  localparam logic [5:0] PTR_ID = 6'h3d;
  localparam logic [5:0] PTR_BANKS = 6'h3f;

  localparam int NREG = 11;
  localparam logic [3:0] IDX_COMMON_VOLTAGE_CHANNEL = 4'h8;
  localparam logic [3:0] IDX_HI = 4'h9;
  localparam logic [3:0] IDX_LO = 4'ha;

  localparam logic [9:0] LEVEL_RST = 10'h200;
  localparam logic [9:0] HI_RST = 10'h3ff;
  localparam logic [9:0] LO_RST = 10'h000;
  localparam logic [1:0] TGT_NV = 2'b01;

  // Arbitrary values
  localparam logic [15:0] CHIP_REV = 16'h0001;
  localparam logic [15:0] CHIP_ID = 16'h5a5a;

  localparam logic [11:0] HC_CMD = 12'h000;
  localparam logic [11:0] HC_DATA = 12'h004;
  localparam logic [11:0] HC_STATUS = 12'h008;
  localparam logic [11:0] HC_RDATA = 12'h00c;

endpackage : gamma_common_voltage_channel_pkg
`default_nettype wire

// *** verilog/gamma_link_if.sv ***
// Two-wire link between host controller and register block.
// Data line is open drain; the line is high unless an end pulls it.
`timescale 1ns/1ns
`default_nettype none
interface gamma_link_if;
  logic sclLine;
  logic sdaLine;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;

  assign sdaLine = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport device (input sclLine, input sdaLine, output devSdaOut,
    output devSdaOe);
  modport host (output sclLine, input sdaLine, output hostSdaOut,
    output hostSdaOe);
endinterface : gamma_link_if
`default_nettype wire

// *** verilog/gamma_common_voltage_channel_device.sv ***
// Register block end: two-wire slave, staged and output channel levels,
// two nonvolatile banks, bank reload and common-voltage clamping.
// Assumes link pins arrive asynchronously and pass two flip-flops.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - One nonvolatile word per transaction only
// - Channels at pointers 00-07, common at 12
// - Host pointer byte has top bits zero
// - Acknowledge pointers to 17; unimplemented read zero
// - Target bits 01 mean nonvolatile write
// - Host ends nonvolatile write with stop
// - Early stop or start leaves word unchanged
// - Nonvolatile write also updates register and output
// - Programming finishes within 250 microseconds
// - Host stays silent 250 microseconds after write
// - Host acquires before reading stored value
// - Limit registers at 1E and 1F
// - Reset: levels 200, high 3FF, low 000
// - Staged layer, outputs change on transfer
// - Common value stored unclamped
// - Above high limit gives high limit
// - Below low limit gives low limit
// - Within limits gives programmed value
// - Inverted limits are ignored
// - Bank pin change reloads all after 750us
// - Bits 15 and 14 clear update staged layer only
// - Bit 15 set transfers all staged values
module gamma_common_voltage_channel_device #(
  parameter int RELOAD_CYCLES = gamma_common_voltage_channel_pkg::RELOAD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  gamma_link_if.device link,
  input wire logic bankSelPin,
  output logic [8:0][9:0] chanLevel,
  output logic nvBusy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b011,
    S_TX = 3'b010,
    S_TACK = 3'b110
  } slave_state_e;

  localparam int NREG = gamma_common_voltage_channel_pkg::NREG;

  function automatic logic [4:0] ptrIndex(input logic [5:0] p);
    if (p <= gamma_common_voltage_channel_pkg::PTR_CH8) ptrIndex = {1'b1, p[3:0]};
    else if (p == gamma_common_voltage_channel_pkg::PTR_COMMON_VOLTAGE_CHANNEL)
      ptrIndex = {1'b1, gamma_common_voltage_channel_pkg::IDX_COMMON_VOLTAGE_CHANNEL};
    else if (p == gamma_common_voltage_channel_pkg::PTR_HI)
      ptrIndex = {1'b1, gamma_common_voltage_channel_pkg::IDX_HI};
    else if (p == gamma_common_voltage_channel_pkg::PTR_LO)
      ptrIndex = {1'b1, gamma_common_voltage_channel_pkg::IDX_LO};
    else ptrIndex = 5'h00;
  endfunction : ptrIndex

  function automatic logic [9:0] clampLevel(input logic [9:0] v,
    input logic [9:0] hi, input logic [9:0] lo);
    if (hi < lo) clampLevel = v;
    else if (v > hi) clampLevel = hi;
    else if (v < lo) clampLevel = lo;
    else clampLevel = v;
  endfunction : clampLevel

  logic [1:0] sclSy, sdaSy, bkSy;
  logic sclQ, sdaQ, bkQ;
  slave_state_e state;
  logic [2:0] bitCnt;
  logic [1:0] byteNum;
  logic addrPh, rdMode, ackWant, ackOn, txLast, sdaLow, wrEv;
  logic [5:0] ptr;
  logic [7:0] hiByte, shiftReg, rdLo;
  logic [15:0] wrWord, rdWord, reloadCnt;
  logic [11:0] nvCnt;
  logic [3:0] nvIdx;
  logic [9:0] nvVal;
  logic nvBank;
  logic [9:0] stageReg [NREG];
  logic [9:0] srcVal [NREG];
  logic [9:0] nvReg [2][NREG];
  logic [9:0] outReg [9];

  // Second flop only feeds the edge-detect flop and the logic below
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclSy <= 2'b11;
      sdaSy <= 2'b11;
      bkSy <= 2'b00;
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      bkQ <= 1'b0;
    end else begin
      sclSy <= {sclSy[0], link.sclLine};
      sdaSy <= {sdaSy[0], link.sdaLine};
      bkSy <= {bkSy[0], bankSelPin};
      sclQ <= sclSy[1];
      sdaQ <= sdaSy[1];
      bkQ <= bkSy[1];
    end
  end

  wire sclRise = sclSy[1] & ~sclQ;
  wire sclFall = ~sclSy[1] & sclQ;
  wire startCond = sclSy[1] & sclQ & sdaQ & ~sdaSy[1];
  wire stopCond = sclSy[1] & sclQ & ~sdaQ & sdaSy[1];
  wire bkEdge = bkSy[1] ^ bkQ;
  wire [7:0] rxByte = {shiftReg[6:0], sdaSy[1]};
  wire [4:0] rxSel = ptrIndex(rxByte[5:0]);
  wire [4:0] ptrSel = ptrIndex(ptr);
  wire ptrAckOk = rxByte[7:6] == 2'b00 &&
    (rxByte[5:0] <= gamma_common_voltage_channel_pkg::PTR_ACK_TOP || rxSel[4] ||
     rxByte[5:0] >= gamma_common_voltage_channel_pkg::PTR_REV);
  wire wrValid = ptrSel[4];
  wire [3:0] wrIdx = ptrSel[3:0];
  wire [9:0] wrVal = wrWord[9:0];
  wire wrNv = wrWord[15:14] == gamma_common_voltage_channel_pkg::TGT_NV;
  wire wrXfer = wrWord[15];
  wire reloadEv = reloadCnt == 16'h0001;
  wire nvCommit = nvCnt == 12'h001;
  wire [9:0] vcomRead = clampLevel(stageReg[gamma_common_voltage_channel_pkg::IDX_COMMON_VOLTAGE_CHANNEL],
    stageReg[gamma_common_voltage_channel_pkg::IDX_HI], stageReg[gamma_common_voltage_channel_pkg::IDX_LO]);

  // Unimplemented pointers read zero
  assign rdWord = !ptrSel[4] ?
    (ptr == gamma_common_voltage_channel_pkg::PTR_REV ? gamma_common_voltage_channel_pkg::CHIP_REV :
     ptr == gamma_common_voltage_channel_pkg::PTR_ID ? gamma_common_voltage_channel_pkg::CHIP_ID :
     ptr == gamma_common_voltage_channel_pkg::PTR_BANKS ? {14'h0000, nvBusy, bkQ} :
     16'h0000) :
    (ptrSel[3:0] == gamma_common_voltage_channel_pkg::IDX_COMMON_VOLTAGE_CHANNEL ? {6'h00, vcomRead} :
     {6'h00, stageReg[ptrSel[3:0]]});
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe = sdaLow;
  assign nvBusy = nvCnt != 12'h000;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bitCnt <= 3'h0;
      byteNum <= 2'h0;
      addrPh <= 1'b0;
      rdMode <= 1'b0;
      ackWant <= 1'b0;
      ackOn <= 1'b0;
      txLast <= 1'b0;
      sdaLow <= 1'b0;
      wrEv <= 1'b0;
      ptr <= 6'h00;
      hiByte <= 8'h00;
      shiftReg <= 8'h00;
      rdLo <= 8'h00;
      wrWord <= 16'h0000;
    end else begin
      wrEv <= 1'b0;
      if (startCond) begin
        state <= S_RX;
        bitCnt <= 3'h0;
        byteNum <= 2'h0;
        addrPh <= 1'b1;
        sdaLow <= 1'b0;
      end else if (stopCond) begin
        state <= S_IDLE;
        sdaLow <= 1'b0;
      end else begin
        case (state)
          S_RX: if (sclRise) begin
            shiftReg <= rxByte;
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= S_ACK;
              ackOn <= 1'b0;
              if (addrPh) begin
                addrPh <= 1'b0;
                ackWant <= rxByte[7:1] == gamma_common_voltage_channel_pkg::BUS_ADDR;
                rdMode <= rxByte[0];
                shiftReg <= rdWord[15:8];
                rdLo <= rdWord[7:0];
                txLast <= 1'b0;
              end else begin
                ackWant <= byteNum == 2'h0 ? ptrAckOk : 1'b1;
                if (byteNum == 2'h0) ptr <= rxByte[5:0];
                if (byteNum == 2'h1) hiByte <= rxByte;
                // Only a complete second byte commits
                if (byteNum == 2'h2) begin
                  wrEv <= 1'b1;
                  wrWord <= {hiByte, rxByte};
                end
                // Later words in the same transaction are dropped
                if (byteNum != 2'h3) byteNum <= byteNum + 2'h1;
              end
            end
          end
          S_ACK: if (sclFall) begin
            if (!ackOn) begin
              sdaLow <= ackWant;
              ackOn <= 1'b1;
              if (!ackWant) state <= S_IDLE;
            end else if (rdMode) begin
              sdaLow <= ~shiftReg[7];
              shiftReg <= {shiftReg[6:0], 1'b0};
              bitCnt <= 3'h1;
              state <= S_TX;
            end else begin
              sdaLow <= 1'b0;
              bitCnt <= 3'h0;
              state <= S_RX;
            end
          end
          S_TX: if (sclFall) begin
            if (bitCnt == 3'h0) begin
              sdaLow <= 1'b0;
              state <= S_TACK;
            end else begin
              sdaLow <= ~shiftReg[7];
              shiftReg <= {shiftReg[6:0], 1'b0};
              bitCnt <= bitCnt + 3'h1;
            end
          end
          S_TACK: if (sclRise) begin
            if (!sdaSy[1] && !txLast) begin
              shiftReg <= rdLo;
              txLast <= 1'b1;
              ackOn <= 1'b1;
              state <= S_ACK;
            end else begin
              state <= S_IDLE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) reloadCnt <= 16'h0000;
    else if (bkEdge) reloadCnt <= 16'(RELOAD_CYCLES);
    else if (reloadCnt != 16'h0000) reloadCnt <= reloadCnt - 16'h0001;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nvCnt <= 12'h000;
      nvIdx <= 4'h0;
      nvVal <= 10'h000;
      nvBank <= 1'b0;
    end else if (wrEv && wrValid && wrNv) begin
      nvCnt <= 12'(gamma_common_voltage_channel_pkg::NV_PROG_CYCLES);
      nvIdx <= wrIdx;
      nvVal <= wrVal;
      nvBank <= bkQ;
    end else if (nvCnt != 12'h000) begin
      nvCnt <= nvCnt - 12'h001;
    end
  end

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    localparam logic [9:0] RST = i == 9 ? gamma_common_voltage_channel_pkg::HI_RST :
      i == 10 ? gamma_common_voltage_channel_pkg::LO_RST : gamma_common_voltage_channel_pkg::LEVEL_RST;
    wire hit = wrEv && wrValid && wrIdx == 4'(i);
    assign srcVal[i] = reloadEv ? nvReg[bkQ][i] : hit ? wrVal : stageReg[i];
    always_ff @(posedge sys_clk) begin
      if (!rst_n) stageReg[i] <= RST;
      else if (reloadEv || hit) stageReg[i] <= srcVal[i];
    end
    for (genvar b = 0; b < 2; b++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (!rst_n) nvReg[b][i] <= RST;
        else if (nvCommit && nvBank == 1'(b) && nvIdx == 4'(i))
          nvReg[b][i] <= nvVal;
      end
    end
    if (i < 9) begin : g_out
      wire load = reloadEv || (wrEv && wrValid && wrXfer) ||
        (hit && wrNv);
      always_ff @(posedge sys_clk) begin
        if (!rst_n) outReg[i] <= gamma_common_voltage_channel_pkg::LEVEL_RST;
        else if (load)
          outReg[i] <= i == 8 ? clampLevel(srcVal[8], srcVal[9], srcVal[10])
            : srcVal[i];
      end
      assign chanLevel[i] = outReg[i];
    end
  end

endmodule : gamma_common_voltage_channel_device
`default_nettype wire

// *** verilog/gamma_common_voltage_channel_host.sv ***
// Host end: APB-programmed two-wire master that writes one word or
// reads one register per command, then holds off after nonvolatile writes.
// Assumes the link data line arrives asynchronously.
`timescale 1ns/1ns
`default_nettype none
module gamma_common_voltage_channel_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  gamma_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BIT = 3'b011,
    H_STOP = 3'b010,
    H_HOLD = 3'b110
  } host_state_e;

  host_state_e state;
  logic [1:0] sdaSy, ph;
  logic [4:0] qCnt;
  logic [3:0] bitN;
  logic [2:0] byteIdx;
  logic sclHigh, sdaLow, ackBad, nackErr, cmdRd;
  logic [5:0] cmdPtr;
  logic [15:0] cmdData, rdShift;
  logic [11:0] holdCnt;
  logic [31:0] rdMux;

  wire sdaIn = sdaSy[1];
  wire busy = state != H_IDLE;
  wire qTick = qCnt == 5'(gamma_common_voltage_channel_pkg::SCL_QTR_CYCLES - 1);
  wire apbWr = psel & penable & pwrite;
  wire launch = apbWr && paddr == gamma_common_voltage_channel_pkg::HC_CMD && !busy;
  wire mapped = paddr == gamma_common_voltage_channel_pkg::HC_CMD ||
    paddr == gamma_common_voltage_channel_pkg::HC_DATA || paddr == gamma_common_voltage_channel_pkg::HC_STATUS ||
    paddr == gamma_common_voltage_channel_pkg::HC_RDATA;
  wire isRx = cmdRd && byteIdx >= 3'h3;
  wire [2:0] lastIdx = cmdRd ? 3'h4 : 3'h3;
  wire isNvWr = !cmdRd && cmdData[15:14] == gamma_common_voltage_channel_pkg::TGT_NV;
  wire [7:0] curByte = byteIdx == 3'h0 ? {gamma_common_voltage_channel_pkg::BUS_ADDR, 1'b0} :
    byteIdx == 3'h1 ? {2'b00, cmdPtr} :
    byteIdx == 3'h2 ? (cmdRd ? {gamma_common_voltage_channel_pkg::BUS_ADDR, 1'b1} :
    cmdData[15:8]) : cmdData[7:0];
  wire driveLow = bitN == 4'h8 ? (isRx && byteIdx != lastIdx) :
    (!isRx && !curByte[~bitN[2:0]]);

  assign rdMux = paddr == gamma_common_voltage_channel_pkg::HC_CMD ?
    {16'h0000, 7'h00, cmdRd, 2'b00, cmdPtr} :
    paddr == gamma_common_voltage_channel_pkg::HC_DATA ? {16'h0000, cmdData} :
    paddr == gamma_common_voltage_channel_pkg::HC_STATUS ?
    {16'h0000, 13'h0000, nackErr, state == H_HOLD, busy} :
    paddr == gamma_common_voltage_channel_pkg::HC_RDATA ? {16'h0000, rdShift} : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign link.sclLine = sclHigh;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe = sdaLow;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdaSy <= 2'b11;
      prdata <= 32'h0000_0000;
      cmdPtr <= 6'h00;
      cmdRd <= 1'b0;
      cmdData <= 16'h0000;
    end else begin
      sdaSy <= {sdaSy[0], link.sdaLine};
      if (psel && !penable && !pwrite) prdata <= rdMux;
      if (launch) begin
        cmdPtr <= pwdata[5:0];
        cmdRd <= pwdata[8];
      end
      if (apbWr && paddr == gamma_common_voltage_channel_pkg::HC_DATA && !busy)
        cmdData <= pwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == H_IDLE || state == H_HOLD) qCnt <= 5'h00;
    else qCnt <= qTick ? 5'h00 : qCnt + 5'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == H_IDLE) ph <= 2'h0;
    else if (qTick) ph <= ph + 2'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= H_IDLE;
      sclHigh <= 1'b1;
      sdaLow <= 1'b0;
      bitN <= 4'h0;
      byteIdx <= 3'h0;
      ackBad <= 1'b0;
      nackErr <= 1'b0;
      rdShift <= 16'h0000;
      holdCnt <= 12'h000;
    end else begin
      case (state)
        H_IDLE: if (launch) begin
          state <= H_START;
          byteIdx <= 3'h0;
          nackErr <= 1'b0;
        end
        H_START: if (qTick) begin
          case (ph)
            2'h0: sdaLow <= 1'b0;
            2'h1: sclHigh <= 1'b1;
            2'h2: sdaLow <= 1'b1;
            default: begin
              sclHigh <= 1'b0;
              bitN <= 4'h0;
              state <= H_BIT;
            end
          endcase
        end
        H_BIT: if (qTick) begin
          case (ph)
            2'h0: sdaLow <= driveLow;
            2'h1: sclHigh <= 1'b1;
            2'h2: begin
              if (bitN == 4'h8) ackBad <= sdaIn;
              else if (isRx) rdShift <= {rdShift[14:0], sdaIn};
            end
            default: begin
              sclHigh <= 1'b0;
              if (bitN != 4'h8) begin
                bitN <= bitN + 4'h1;
              end else begin
                bitN <= 4'h0;
                if (!isRx && ackBad) begin
                  nackErr <= 1'b1;
                  state <= H_STOP;
                end else if (byteIdx == lastIdx) begin
                  state <= H_STOP;
                end else begin
                  byteIdx <= byteIdx + 3'h1;
                  if (cmdRd && byteIdx == 3'h1) state <= H_START;
                end
              end
            end
          endcase
        end
        H_STOP: if (qTick) begin
          case (ph)
            2'h0: sdaLow <= 1'b1;
            2'h1: sclHigh <= 1'b1;
            2'h2: sdaLow <= 1'b0;
            default: begin
              if (isNvWr && !nackErr) begin
                state <= H_HOLD;
                holdCnt <= 12'(gamma_common_voltage_channel_pkg::NV_PROG_CYCLES);
              end else begin
                state <= H_IDLE;
              end
            end
          endcase
        end
        H_HOLD: begin
          holdCnt <= holdCnt - 12'h001;
          if (holdCnt == 12'h001) state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule : gamma_common_voltage_channel_host
`default_nettype wire

// *** verif/gamma_link_sva.sv ***
// Checker on the two-wire link, the channel outputs and the bank pin.
// Assumes one clock domain; the bench instantiates it beside the link.
`timescale 1ns/1ns
`default_nettype none
module gamma_link_sva #(
  parameter int RELOAD_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclLine,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic bankSelPin,
  input wire logic [8:0][9:0] chanLevel,
  input wire logic nvBusy
);
  localparam int RLO = RELOAD_CYCLES;
  localparam int RHI = RELOAD_CYCLES + 10;
  logic [12:0] busyCnt;
  logic [3:0] lvlAge;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Length of the current programming phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !nvBusy) busyCnt <= 13'h0000;
    else busyCnt <= busyCnt + 13'h0001;
  end
  // Cycles since the outputs last moved
  always_ff @(posedge sys_clk) begin
    if (!rst_n || $changed(chanLevel)) lvlAge <= 4'h0;
    else if (lvlAge != 4'hf) lvlAge <= lvlAge + 4'h1;
  end

  reset_levels_a: assert property (
    $rose(rst_n) |-> chanLevel == {9{gamma_common_voltage_channel_pkg::LEVEL_RST}})
    else $error("outputs not mid-scale after reset");
  nv_prog_time_a: assert property (
    nvBusy |-> busyCnt <= 13'(gamma_common_voltage_channel_pkg::NV_PROG_CYCLES))
    else $error("nonvolatile programming too long");
  nv_quiet_a: assert property (
    busyCnt > 13'h0190 |-> sclLine && !hostSdaOe)
    else $error("link busy during programming");
  nv_output_a: assert property (
    $rose(nvBusy) |-> ##[0:4] lvlAge < 4'h8)
    else $error("output not updated by nonvolatile write");
  stage_hold_a: assert property (
    (!sclLine) [*6] |-> $stable(chanLevel))
    else $error("outputs moved with clock line low");
  ack_timing_a: assert property (
    $changed(devSdaOe) |-> !sclLine)
    else $error("device data changed with clock high");
  bank_wait_a: assert property (
    $changed(bankSelPin) |=> $stable(chanLevel) [*8])
    else $error("outputs reloaded too early");
  bank_reload_a: assert property (
    $changed(bankSelPin) |-> ##[RLO:RHI] $changed(chanLevel))
    else $error("outputs not reloaded after bank change");
endmodule : gamma_link_sva
`default_nettype wire

// *** verif/test_gamma_common_voltage_channel_register_nv_control.sv ***
// Bench: APB host controller driving the register block over the link.
// Assumes the package, the link interface and both design ends.
`timescale 1ns/1ns
`default_nettype none
module test_gamma_common_voltage_channel_register_nv_control;
  localparam int RLD = 50;
  localparam int LIMIT = 100000;
  localparam logic [3:0][9:0] VIN = {10'h3f0, 10'h100, 10'h180, 10'h050};
  localparam logic [3:0][9:0] VEXP = {10'h300, 10'h100, 10'h180, 10'h100};
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic bankSelPin, nvBusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, stat;
  logic [8:0][9:0] chanLevel;
  int n_errors, samples_checked, cycleCount;

  gamma_link_if gamma_link_if_inst ();
  gamma_common_voltage_channel_device #(.RELOAD_CYCLES(RLD)) gamma_common_voltage_channel_device_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(gamma_link_if_inst.device),
    .bankSelPin(bankSelPin), .chanLevel(chanLevel), .nvBusy(nvBusy));
  gamma_common_voltage_channel_host gamma_common_voltage_channel_host_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(gamma_link_if_inst.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  gamma_link_sva #(.RELOAD_CYCLES(RLD)) gamma_link_sva_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclLine(gamma_link_if_inst.sclLine),
    .hostSdaOe(gamma_link_if_inst.hostSdaOe),
    .devSdaOe(gamma_link_if_inst.devSdaOe), .bankSelPin(bankSelPin),
    .chanLevel(chanLevel), .nvBusy(nvBusy));

  always #50 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One link transfer; waits until the controller and holdoff are idle
  task automatic xfer(input logic [5:0] p, input logic [15:0] w,
    input logic rd);
    apb(1'b1, gamma_common_voltage_channel_pkg::HC_DATA, {16'h0000, w}, q);
    apb(1'b1, gamma_common_voltage_channel_pkg::HC_CMD, {23'h00_0000, rd, 2'h0, p}, q);
    do apb(1'b0, gamma_common_voltage_channel_pkg::HC_STATUS, 32'h0000_0000, stat);
    while (stat[1:0] !== 2'h0);
    if (rd) apb(1'b0, gamma_common_voltage_channel_pkg::HC_RDATA, 32'h0000_0000, q);
  endtask : xfer

  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    bankSelPin = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cycleCount = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      check(16'(chanLevel[i]), 16'(gamma_common_voltage_channel_pkg::LEVEL_RST));
    end
    xfer(gamma_common_voltage_channel_pkg::PTR_HI, 16'h0000, 1'b1);
    check(q[15:0], 16'(gamma_common_voltage_channel_pkg::HI_RST));
    xfer(gamma_common_voltage_channel_pkg::PTR_LO, 16'h0000, 1'b1);
    check(q[15:0], 16'(gamma_common_voltage_channel_pkg::LO_RST));
    // Acknowledged but unimplemented, then refused
    xfer(6'h0a, 16'h0000, 1'b1);
    check(q[15:0], 16'h0000);
    check(16'(stat[2]), 16'h0000);
    xfer(6'h18, 16'h0000, 1'b1);
    check(16'(stat[2]), 16'h0001);
    apb(1'b0, 12'h010, 32'h0000_0000, q);
    check(16'(perr), 16'h0001);
    // Staged write, then transfer through another channel
    xfer(6'h01, 16'h0155, 1'b0);
    check(16'(chanLevel[1]), 16'(gamma_common_voltage_channel_pkg::LEVEL_RST));
    xfer(gamma_common_voltage_channel_pkg::PTR_CH8, 16'h80aa, 1'b0);
    check(16'(chanLevel[1]), 16'h0155);
    check(16'(chanLevel[7]), 16'h00aa);
    // Clamp window 0x100..0x300
    xfer(gamma_common_voltage_channel_pkg::PTR_HI, 16'h0300, 1'b0);
    xfer(gamma_common_voltage_channel_pkg::PTR_LO, 16'h0100, 1'b0);
    for (int i = 0; i < 4; i++) begin
      xfer(gamma_common_voltage_channel_pkg::PTR_COMMON_VOLTAGE_CHANNEL, 16'h8000 | 16'(VIN[i]), 1'b0);
      check(16'(chanLevel[8]), 16'(VEXP[i]));
    end
    xfer(gamma_common_voltage_channel_pkg::PTR_COMMON_VOLTAGE_CHANNEL, 16'h0000, 1'b1);
    check(q[15:0], 16'h0300);
    xfer(gamma_common_voltage_channel_pkg::PTR_HI, 16'h0080, 1'b0);
    xfer(gamma_common_voltage_channel_pkg::PTR_LO, 16'h0200, 1'b0);
    xfer(gamma_common_voltage_channel_pkg::PTR_COMMON_VOLTAGE_CHANNEL, 16'h83f0, 1'b0);
    check(16'(chanLevel[8]), 16'h03f0);
    // Nonvolatile write into bank 0
    fork
      xfer(6'h02, 16'h42c3, 1'b0);
      begin
        while (nvBusy !== 1'b1) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check(16'(chanLevel[2]), 16'h02c3);
        check(16'(nvBusy), 16'h0001);
      end
    join
    check(16'(nvBusy), 16'h0000);
    // Bank switch away and back
    bankSelPin <= 1'b1;
    repeat (RLD + 10) @(posedge sys_clk);
    check(16'(chanLevel[2]), 16'(gamma_common_voltage_channel_pkg::LEVEL_RST));
    check(16'(chanLevel[7]), 16'(gamma_common_voltage_channel_pkg::LEVEL_RST));
    bankSelPin <= 1'b0;
    repeat (RLD + 10) @(posedge sys_clk);
    check(16'(chanLevel[2]), 16'h02c3);
    // Stored word read back once loaded into the register
    xfer(6'h02, 16'h0000, 1'b1);
    check(q[15:0], 16'h02c3);
    complete_run();
  end
endmodule : test_gamma_common_voltage_channel_register_nv_control
`default_nettype wire
